// File: pscu_defs.vh
// constants for the pin state control unit
`ifndef PSCU_DEFS_VH
`define PSCU_DEFS_VH

// register offsets (2-bit index)
`define PSCU_REG_PORT_DDR 2'h0
`define PSCU_REG_PORT_DATA 2'h1
`define PSCU_REG_UPPER_DDR 2'h2
`define PSCU_REG_STATUS 2'h3

// reset values
`define PSCU_PORT_DDR_RST 8'h00
`define PSCU_PORT_DATA_RST 8'h00
`define PSCU_UPPER_DDR_RST 4'h0

// status register field positions
`define PSCU_ST_IN_RESET 0
`define PSCU_ST_HW_HW_STANDBY_REQUEST_N 1
`define PSCU_ST_WDT_CAUSE 2
`define PSCU_ST_ADDR_HOLD 3
`define PSCU_ST_SW_HW_STANDBY_REQUEST_N 4
`define PSCU_ST_BUS_REL 5

// bus state codes from the bus controller
`define PSCU_BS_IDLE 3'h0
`define PSCU_BS_FIRST 3'h1
`define PSCU_BS_SECOND 3'h2
`define PSCU_BS_THIRD 3'h3
`define PSCU_BS_WAIT 3'h4

// operating modes
`define PSCU_MODE_EXP_HI 3'h4
`define PSCU_MODE_EXP_MAX 3'h5
`define PSCU_MODE_UPPER_LO 3'h3
`define PSCU_MODE_UPPER_HI 3'h4

// timing of the reset and standby sequence (other party keeps these)
`define PSCU_HW_STANDBY_REQUEST_N_LEAD_CYCLES 10
`define PSCU_EXIT_LEAD_NS 100

`endif

// File: pscu_keep_cell.v
// pin group cell with keep, tri-state and normal drive
`timescale 1ns/1ps
module pscu_keep_cell #(
    parameter W = 8
) (
    // clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    input wire ce_i,
    // condition
    input wire tri_i,
    input wire keep_i,
    input wire [W-1:0] keep_oe_i,
    // normal function
    input wire [W-1:0] val_i,
    input wire [W-1:0] oe_i,
    // pins
    output reg [W-1:0] pin_o,
    output reg [W-1:0] pin_oe_o
);

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        pin_o <= {W{1'b0}};
        pin_oe_o <= {W{1'b0}};
    end else if (ce_i) begin
        if (tri_i) begin
            pin_oe_o <= {W{1'b0}};
        end else if (keep_i) begin
            // keep last level
            // value frozen; inputs float, outputs hold
            pin_oe_o <= keep_oe_i;
        end else begin
            pin_o <= val_i;
            pin_oe_o <= oe_i;
        end
    end
end

endmodule

// File: pscu_monitor.sv
// assertion checker for the pin state control unit
`timescale 1ns/1ps
`include "pscu_defs.vh"
module pscu_monitor (
    // clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // board pins and chip state
    input wire chip_init_n_i,
    input wire hw_standby_request_n_i,
    input wire wdt_reset_i,
    input wire sw_standby_i,
    input wire [2:0] bus_state_i,
    input wire two_state_area_i,
    // driven pins
    input wire reset_out_n_o,
    input wire reset_out_n_oe_o,
    input wire [19:0] addr_o,
    input wire addr_oe_o,
    input wire addr_strobe_n_o,
    input wire read_strobe_n_o,
    input wire high_byte_write_n_o,
    input wire low_byte_write_n_o,
    input wire strobe_oe_o,
    input wire data_oe_o,
    input wire [3:0] upper_oe_o,
    input wire [7:0] port_o,
    input wire [7:0] port_oe_o
);
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    // board reset pin seen high, then low at two rising edges
    sequence s_init_fall;
        chip_init_n_i ##1 !chip_init_n_i [*2];
    endsequence

    property p_rso_drv;
        reset_out_n_oe_o |-> !reset_out_n_o && $past(wdt_reset_i);
    endproperty
    a_rso_drv: assert property (p_rso_drv)
        else $error("reset out driven without watchdog");
    property p_rso_off;
        !wdt_reset_i [*2] |-> !reset_out_n_oe_o;
    endproperty
    a_rso_off: assert property (p_rso_off)
        else $error("reset out not floated");
    // strobes forced at the edge after the falling-edge sample
    property p_strobe;
        !chip_init_n_i [*2] |-> addr_strobe_n_o && read_strobe_n_o
            && high_byte_write_n_o && low_byte_write_n_o && !data_oe_o;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobes or data bus active in reset");
    property p_port_in;
        !chip_init_n_i [*4] |-> port_oe_o == 8'h00 && upper_oe_o == 4'h0;
    endproperty
    a_port_in: assert property (p_port_in)
        else $error("port pin still output in reset");
    property p_addr_low;
        s_init_fall ##0 (bus_state_i == `PSCU_BS_FIRST
            || bus_state_i == `PSCU_BS_WAIT
            || bus_state_i == `PSCU_BS_SECOND && !two_state_area_i)
            |=> addr_o == 20'h00000;
    endproperty
    a_addr_low: assert property (p_addr_low)
        else $error("address not low half state after sample");
    property p_addr_hold;
        s_init_fall ##0 (bus_state_i == `PSCU_BS_THIRD
            || bus_state_i == `PSCU_BS_SECOND && two_state_area_i)
            |=> $stable(addr_o) ##1 addr_o == 20'h00000;
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address not held to end of state");
    property p_hw_float;
        !hw_standby_request_n_i [*5] |-> port_oe_o == 8'h00
            && upper_oe_o == 4'h0 && !addr_oe_o && !data_oe_o
            && !strobe_oe_o && !reset_out_n_oe_o;
    endproperty
    a_hw_float: assert property (p_hw_float)
        else $error("pin driven in hardware standby");
    // no register writes are expected while the core is stopped
    property p_keep;
        sw_standby_i [*3] ##0 (chip_init_n_i && hw_standby_request_n_i
            && !wdt_reset_i) |=> $stable(port_o) && $stable(port_oe_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("port pins not kept in standby");

    c_hold: cover property (s_init_fall ##0 bus_state_i == `PSCU_BS_THIRD);
    c_hw_standby_request_n: cover property (!hw_standby_request_n_i [*4]);
    c_rso: cover property (reset_out_n_oe_o);
endmodule

bind pscu_top pscu_monitor u_mon (.*);

// File: pscu_sup_model.sv
// supervisor model for the board reset and standby pins
`timescale 1ns/1ps
module pscu_sup_model #(
    parameter EXIT_LEAD = 20
) (
    // clock
    input wire clk_sys_i,
    // board pins
    output reg chip_init_n_o,
    output reg hw_standby_request_n_o
);
    initial begin
        chip_init_n_o = 1'b1;
        hw_standby_request_n_o = 1'b1;
    end
    // tasks are entered at a rising edge and drive by nba
    task set_init(input v);
        chip_init_n_o <= v;
    endtask
    task enter_hw_standby_request_n(input keep_ram);
        begin
            // reset lead only when ram kept
            if (keep_ram) begin
                chip_init_n_o <= 1'b0;
                repeat (10) @(posedge clk_sys_i);
            end
            hw_standby_request_n_o <= 1'b0;
            @(posedge clk_sys_i);
            chip_init_n_o <= 1'b1;
        end
    endtask
    task exit_hw_standby_request_n;
        begin
            chip_init_n_o <= 1'b0;
            repeat (EXIT_LEAD) @(posedge clk_sys_i);
            hw_standby_request_n_o <= 1'b1;
            repeat (6) @(posedge clk_sys_i);
            chip_init_n_o <= 1'b1;
        end
    endtask
endmodule

// File: pscu_top.v
// pin state control across reset, standby and bus release
// ----------------------------------------------------------------
// Function
// - keep: inputs float, outputs hold level
// - reset output low only on watchdog reset
// - reset makes all port pins inputs
// - reset forces strobes high, data bus off
// - address low half state after sample
// - reset input sampled on clock fall
// - wait state reset treated as second
// - third state reset holds address till end
// - two-state area second acts as third
// - upper pins in software standby follow direction
// - upper pins bus-released follow timer and direction in upper address modes, direction only otherwise
// ----------------------------------------------------------------
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "pscu_defs.vh"
module pscu_top (
    // clock, reset, enable
    input wire clk_sys_i,
    input wire nrst_i,
    input wire ce_i,
    // board pins
    input wire chip_init_n_i,
    input wire hw_standby_request_n_i,
    output wire reset_out_n_o,
    output wire reset_out_n_oe_o,
    // chip state from core
    input wire [2:0] op_mode_i,
    input wire wdt_reset_i,
    input wire sw_standby_i,
    input wire bus_released_i,
    input wire onchip_ram_enable_i,
    // bus controller side
    input wire [2:0] bus_state_i,
    input wire two_state_area_i,
    input wire [23:0] core_addr_i,
    input wire core_addr_strobe_n_i,
    input wire core_read_strobe_n_i,
    input wire core_high_byte_write_n_i,
    input wire core_low_byte_write_n_i,
    input wire [15:0] core_data_i,
    input wire core_data_oe_i,
    input wire [3:0] timer_oe_i,
    // external bus pins
    output reg [19:0] addr_o,
    output reg addr_oe_o,
    output wire addr_strobe_n_o,
    output wire read_strobe_n_o,
    output wire high_byte_write_n_o,
    output wire low_byte_write_n_o,
    output wire strobe_oe_o,
    output reg [15:0] data_o,
    output wire data_oe_o,
    // upper address pins
    output wire [3:0] upper_o,
    output wire [3:0] upper_oe_o,
    // general port pins
    input wire [7:0] port_i,
    output wire [7:0] port_o,
    output wire [7:0] port_oe_o,
    // register port
    input wire [1:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o
);

// ----------------------------------------------------------------
// functions
// ----------------------------------------------------------------
function is_expanded;
    input [2:0] m;
    begin
        is_expanded = (m != 3'h0) && (m <= `PSCU_MODE_EXP_MAX);
    end
endfunction

// ----------------------------------------------------------------
// state machine codes
// ----------------------------------------------------------------
localparam [2:0] ST_RUN = 3'h1;
localparam [2:0] ST_RST = 3'h2;
localparam [2:0] ST_HSB = 3'h4;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg init_meta_r;
reg init_sync_n_r;
reg hw_standby_request_n_meta_r;
reg hw_standby_request_n_sync_n_r;
reg [7:0] pin_meta_r;
reg [7:0] pin_sync_r;

// falling edge sample
// the reset pin is taken on the clock fall, so the next rising
// edge lands half a state after the sample
always @(negedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        init_meta_r <= 1'b0;
        init_sync_n_r <= 1'b0;
    end else if (ce_i) begin
        init_meta_r <= chip_init_n_i;
        init_sync_n_r <= init_meta_r;
    end
end

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        hw_standby_request_n_meta_r <= 1'b1;
        hw_standby_request_n_sync_n_r <= 1'b1;
        pin_meta_r <= 8'h00;
        pin_sync_r <= 8'h00;
    end else if (ce_i) begin
        hw_standby_request_n_meta_r <= hw_standby_request_n_i;
        hw_standby_request_n_sync_n_r <= hw_standby_request_n_meta_r;
        pin_meta_r <= port_i;
        pin_sync_r <= pin_meta_r;
    end
end

// ----------------------------------------------------------------
// operating state
// ----------------------------------------------------------------
reg [2:0] state_r;
reg [2:0] state_nxt;
wire rst_now;
wire hw_hw_standby_request_n;
wire expanded;
wire upper_mode;

assign rst_now = !init_sync_n_r || wdt_reset_i;
assign hw_hw_standby_request_n = state_r == ST_HSB;
assign expanded = is_expanded(op_mode_i);
assign upper_mode = (op_mode_i >= `PSCU_MODE_UPPER_LO) &&
                    (op_mode_i <= `PSCU_MODE_UPPER_HI);

// standby has priority; the supervisor orders reset around it
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_RUN: begin
            if (!hw_standby_request_n_sync_n_r) begin
                state_nxt = ST_HSB;
            end else if (rst_now) begin
                state_nxt = ST_RST;
            end
        end
        ST_RST: begin
            if (!hw_standby_request_n_sync_n_r) begin
                state_nxt = ST_HSB;
            end else if (!rst_now) begin
                state_nxt = ST_RUN;
            end
        end
        ST_HSB: begin
            // exit goes through reset
            // leaving standby always lands in reset first
            if (hw_standby_request_n_sync_n_r) begin
                state_nxt = ST_RST;
            end
        end
        default: begin
            state_nxt = ST_RST;
        end
    endcase
end

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        state_r <= ST_RST;
    end else if (ce_i) begin
        state_r <= state_nxt;
    end
end

// ----------------------------------------------------------------
// address bus across a reset
// ----------------------------------------------------------------
reg rst_d_r;
reg addr_hold_r;
wire rst_rise;
wire late_state;

assign rst_rise = rst_now && !rst_d_r;
assign late_state = (bus_state_i == `PSCU_BS_THIRD) ||
                    ((bus_state_i == `PSCU_BS_SECOND) &&
                     two_state_area_i);

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        rst_d_r <= 1'b1;
        addr_hold_r <= 1'b0;
        addr_o <= 20'h00000;
        addr_oe_o <= 1'b0;
    end else if (ce_i) begin
        rst_d_r <= rst_now;
        // hold lasts exactly the one state still running
        addr_hold_r <= rst_rise && late_state && !hw_hw_standby_request_n;
        if (hw_hw_standby_request_n || !hw_standby_request_n_sync_n_r) begin
            addr_oe_o <= 1'b0;
        end else if (rst_rise && late_state) begin
            addr_oe_o <= expanded;
        end else if (rst_now) begin
            // wait state as second
            // first, second and wait states all end up here
            addr_o <= 20'h00000;
            addr_oe_o <= expanded &&
                         (op_mode_i <= `PSCU_MODE_EXP_HI);
        end else if (sw_standby_i || bus_released_i) begin
            addr_oe_o <= 1'b0;
        end else begin
            addr_o <= core_addr_i[19:0];
            addr_oe_o <= expanded;
        end
    end
end

// ----------------------------------------------------------------
// strobes and data bus
// ----------------------------------------------------------------
reg [3:0] strobe_r;
reg data_oe_r;
reg strobe_oe_r;

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        strobe_r <= 4'hF;
        data_oe_r <= 1'b0;
        data_o <= 16'h0000;
        strobe_oe_r <= 1'b0;
    end else if (ce_i) begin
        strobe_r <= {core_addr_strobe_n_i, core_read_strobe_n_i,
                     core_high_byte_write_n_i,
                     core_low_byte_write_n_i};
        data_o <= core_data_i;
        data_oe_r <= core_data_oe_i && expanded;
        strobe_oe_r <= expanded && !sw_standby_i &&
                       !bus_released_i;
    end
end

// strobes high, data off
// override is combinational so the registered copy of an
// access in flight never leaks past the reset sample
assign addr_strobe_n_o = rst_now ? 1'b1 : strobe_r[3];
assign read_strobe_n_o = rst_now ? 1'b1 : strobe_r[2];
assign high_byte_write_n_o = rst_now ? 1'b1 : strobe_r[1];
assign low_byte_write_n_o = rst_now ? 1'b1 : strobe_r[0];
assign strobe_oe_o = !hw_hw_standby_request_n &&
                     (rst_now ? expanded : strobe_oe_r);
assign data_oe_o = data_oe_r && !rst_now && !hw_hw_standby_request_n;

// ----------------------------------------------------------------
// reset output pin
// ----------------------------------------------------------------
reg rst_out_oe_r;

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        rst_out_oe_r <= 1'b0;
    end else if (ce_i) begin
        rst_out_oe_r <= wdt_reset_i && !hw_hw_standby_request_n;
    end
end

assign reset_out_n_o = 1'b0;
assign reset_out_n_oe_o = rst_out_oe_r;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [7:0] port_ddr_r;
reg [7:0] port_data_r;
reg [3:0] upper_ddr_r;
reg [7:0] status;

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        port_ddr_r <= `PSCU_PORT_DDR_RST;
        port_data_r <= `PSCU_PORT_DATA_RST;
        upper_ddr_r <= `PSCU_UPPER_DDR_RST;
    end else if (ce_i) begin
        if (rst_now || hw_hw_standby_request_n) begin
            port_ddr_r <= `PSCU_PORT_DDR_RST;
            upper_ddr_r <= `PSCU_UPPER_DDR_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `PSCU_REG_PORT_DDR: begin
                    port_ddr_r <= reg_wdata_i;
                end
                `PSCU_REG_PORT_DATA: begin
                    port_data_r <= reg_wdata_i;
                end
                `PSCU_REG_UPPER_DDR: begin
                    upper_ddr_r <= reg_wdata_i[3:0];
                end
                default: begin
                end
            endcase
        end
    end
end

always @* begin
    status = 8'h00;
    status[`PSCU_ST_IN_RESET] = rst_now;
    status[`PSCU_ST_HW_HW_STANDBY_REQUEST_N] = hw_hw_standby_request_n;
    status[`PSCU_ST_WDT_CAUSE] = wdt_reset_i;
    status[`PSCU_ST_ADDR_HOLD] = addr_hold_r;
    status[`PSCU_ST_SW_HW_STANDBY_REQUEST_N] = sw_standby_i;
    status[`PSCU_ST_BUS_REL] = bus_released_i;
end

// data port reads return synchronised pin levels
always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
        if (reg_rd_i) begin
            case (reg_addr_i)
                `PSCU_REG_PORT_DDR: begin
                    reg_rdata_o <= port_ddr_r;
                end
                `PSCU_REG_PORT_DATA: begin
                    reg_rdata_o <= pin_sync_r;
                end
                `PSCU_REG_UPPER_DDR: begin
                    reg_rdata_o <= {4'h0, upper_ddr_r};
                end
                default: begin
                    reg_rdata_o <= status;
                end
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
end

// ----------------------------------------------------------------
// pin groups
// ----------------------------------------------------------------
wire port_tri;
wire port_keep;
wire upper_tri;
wire upper_keep;
wire [3:0] upper_keep_oe;
wire [3:0] upper_val;
wire [3:0] upper_oe;

assign port_tri = rst_now || hw_hw_standby_request_n;
assign port_keep = sw_standby_i || bus_released_i;
assign upper_tri = rst_now || hw_hw_standby_request_n;
assign upper_keep = sw_standby_i || bus_released_i;
assign upper_keep_oe = !upper_mode ? upper_ddr_r :
                       bus_released_i ? (upper_ddr_r & timer_oe_i) :
                       upper_ddr_r;
assign upper_val = upper_mode ? core_addr_i[23:20] : port_data_r[3:0];
assign upper_oe = upper_mode ? 4'hF : upper_ddr_r;

pscu_keep_cell #(
    .W(8)
) u_port (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tri_i(port_tri),
    .keep_i(port_keep),
    .keep_oe_i(port_ddr_r),
    .val_i(port_data_r),
    .oe_i(port_ddr_r),
    .pin_o(port_o),
    .pin_oe_o(port_oe_o)
);

pscu_keep_cell #(
    .W(4)
) u_upper (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tri_i(upper_tri),
    .keep_i(upper_keep),
    .keep_oe_i(upper_keep_oe),
    .val_i(upper_val),
    .oe_i(upper_oe),
    .pin_o(upper_o),
    .pin_oe_o(upper_oe_o)
);

// onchip_ram_enable_i is not used here: RAM retention
// timing (ten-cycle lead, hold until standby) is the supervisor's
wire unused_ram_en;
assign unused_ram_en = onchip_ram_enable_i;

endmodule

// File: tb_pin_state_reset_standby_control.sv
// bench for the pin state control unit
`timescale 1ns/1ps
module tb_pin_state_reset_standby_control;
    // bus states tried: first, second, wait, third, two-state second
    localparam [14:0] ST = {3'h2, 3'h3, 3'h4, 3'h2, 3'h1};
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg [2:0] mode = 3'h1;
    reg [2:0] bst = 3'h0;
    reg wdt = 1'b0, sws = 1'b0, brl = 1'b0, onchip_ram_enable = 1'b0, two = 1'b0;
    reg [3:0] cstb = 4'hF;
    reg [3:0] tmr = 4'h0;
    reg cdoe = 1'b0;
    reg [1:0] ra = 2'h0;
    reg [7:0] wd = 8'h00;
    reg wr = 1'b0, rd = 1'b0;
    reg ce = 1'b1;
    reg [23:0] cadr = 24'h0ABCDE;
    reg [15:0] cdat = 16'h1234;
    reg [7:0] pin = 8'h3C;
    wire [15:0] dout;
    wire [3:0] up_o;
    wire init_n, hw_standby_request_n_n, rso, rso_oe, addr_oe, stb_oe, dat_oe;
    wire as_n, rd_n, hw_n, lw_n;
    wire [19:0] addr;
    wire [3:0] up_oe;
    wire [7:0] po, poe, rdata;
    integer failures = 0, n_compared = 0, cyc = 0, i;

    pscu_top u_dut (
        .clk_sys_i(clk), .nrst_i(nrst), .ce_i(ce),
        .chip_init_n_i(init_n), .hw_standby_request_n_i(hw_standby_request_n_n),
        .reset_out_n_o(rso), .reset_out_n_oe_o(rso_oe),
        .op_mode_i(mode), .wdt_reset_i(wdt), .sw_standby_i(sws),
        .bus_released_i(brl), .onchip_ram_enable_i(onchip_ram_enable),
        .bus_state_i(bst), .two_state_area_i(two),
        .core_addr_i(cadr), .core_addr_strobe_n_i(cstb[3]),
        .core_read_strobe_n_i(cstb[2]), .core_high_byte_write_n_i(cstb[1]),
        .core_low_byte_write_n_i(cstb[0]), .core_data_i(cdat),
        .core_data_oe_i(cdoe), .timer_oe_i(tmr), .addr_o(addr),
        .addr_oe_o(addr_oe), .addr_strobe_n_o(as_n), .read_strobe_n_o(rd_n),
        .high_byte_write_n_o(hw_n), .low_byte_write_n_o(lw_n),
        .strobe_oe_o(stb_oe), .data_o(dout), .data_oe_o(dat_oe),
        .upper_o(up_o),
        .upper_oe_o(up_oe), .port_i(pin), .port_o(po), .port_oe_o(poe),
        .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata)
    );
    pscu_sup_model u_sup (
        .clk_sys_i(clk), .chip_init_n_o(init_n),
        .hw_standby_request_n_o(hw_standby_request_n_n)
    );

    always #2.5 clk = ~clk;
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task chk(input string nm, input [23:0] e, input [23:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("unexpected %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // entered at a rising edge; leaves a free edge after the strobe
    task wr_reg(input [1:0] a, input [7:0] d);
        begin
            ra <= a;
            wd <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd_reg(input [1:0] a, input [7:0] e, input string nm);
        begin
            ra <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            chk(nm, e, rdata);
            @(posedge clk);
        end
    endtask
    task finish_test;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // the tests take about 210 cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        rd_reg(2'h0, 8'h00, "port_ddr");
        rd_reg(2'h2, 8'h00, "upper_ddr");
        wr_reg(2'h3, 8'hFF);
        rd_reg(2'h3, 8'h00, "status");
        wr_reg(2'h0, 8'h55);
        wr_reg(2'h1, 8'hA5);
        wr_reg(2'h2, 8'h0A);
        ce <= 1'b0;
        wr_reg(2'h0, 8'hAA);
        ce <= 1'b1;
        rd_reg(2'h0, 8'h55, "ddr_frozen");
        rd_reg(2'h1, 8'h3C, "port_pins");
        #1;
        chk("upper_pins", 4'h5, up_o);
        @(posedge clk);
        mode <= 3'h3;
        sws <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("keep_oe", 8'h55, poe);
        chk("keep_pins", 8'h05, po & 8'h55);
        chk("upper_sw", 4'hA, up_oe);
        chk("upper_keep", 4'h5, up_o);
        @(posedge clk);
        sws <= 1'b0;
        brl <= 1'b1;
        tmr <= 4'h6;
        repeat (4) @(posedge clk);
        #1;
        chk("upper_rel", 4'h2, up_oe);
        @(posedge clk);
        brl <= 1'b0;
        tmr <= 4'h0;
        mode <= 3'h1;
        wdt <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("rso_oe", 1'b1, rso_oe);
        chk("rso", 1'b0, rso);
        @(posedge clk);
        wdt <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("rso_off", 1'b0, rso_oe);
        for (i = 0; i < 5; i = i + 1) begin
            @(posedge clk);
            bst <= ST[i*3 +: 3];
            two <= (i == 4);
            cstb <= 4'h0;
            cdoe <= 1'b1;
            wr_reg(2'h0, 8'h55);
            @(posedge clk);
            #1;
            chk("strb_run", 4'h0, {as_n, rd_n, hw_n, lw_n});
            chk("dat_run", 17'h11234, {dat_oe, dout});
            @(posedge clk);
            u_sup.set_init(1'b0);
            repeat (2) @(posedge clk);
            #1;
            chk("strobes", 4'hF, {as_n, rd_n, hw_n, lw_n});
            chk("data_oe", 1'b0, dat_oe);
            chk("addr_1st", (i > 2) ? 20'hABCDE : 20'h0, addr);
            @(posedge clk);
            #1;
            chk("addr_2nd", 20'h0, addr);
            chk("port_in", 8'h00, poe);
            @(posedge clk);
            u_sup.set_init(1'b1);
            repeat (6) @(posedge clk);
        end
        bst <= 3'h0;
        two <= 1'b0;
        cstb <= 4'hF;
        onchip_ram_enable <= 1'b1;
        u_sup.enter_hw_standby_request_n(1'b1);
        repeat (3) @(posedge clk);
        #1;
        chk("hw_standby_request_n_ram", 16'h0, {poe, up_oe, addr_oe, dat_oe, stb_oe, rso_oe});
        @(posedge clk);
        u_sup.exit_hw_standby_request_n();
        repeat (6) @(posedge clk);
        onchip_ram_enable <= 1'b0;
        wr_reg(2'h0, 8'h55);
        repeat (2) @(posedge clk);
        #1;
        chk("run_oe", 8'h55, poe);
        @(posedge clk);
        u_sup.enter_hw_standby_request_n(1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk("hw_standby_request_n_off", 16'h0, {poe, up_oe, addr_oe, dat_oe, stb_oe, rso_oe});
        @(posedge clk);
        u_sup.exit_hw_standby_request_n();
        repeat (4) @(posedge clk);
        finish_test;
    end
endmodule
